//--- src/fp_pkg.sv
// Contract
// R1: serial port runs as I2C when the interface select is 1, SPI when 0.
// R2: interface select pulled high inside, so a floating select means I2C.
// R3: data pin two-way for I2C and 3-wire SPI, input only in 4-wire SPI.
// R4: address-one pin is bit A1 in I2C, driven serial data out in 4-wire SPI.
// R5: host supplies serial clock in both modes; transfers are timed from it.
// R6: address-zero pin is A0 in I2C, active-low pulled-up chip select in SPI.
// R7: interrupt output goes low whenever any monitored status changes.
// R8: power-down input low keeps low-power mode; pull-up means normal when open.
// R9: reset input low is power-on reset: logic and registers to defaults; low_power_q and div_reset_q are cleared only by rst.
// R10: all clock outputs stay disabled while device reset is in effect.
// R11: output-enable input high disables every output; pull-down enables if open; oe_n gates only clk_out_en_q.
// R12: lock output high while the loop is locked, low while out of lock; device reset sets lock_lost_n_oe_q, so the pin is low then even when locked.
// R13: synchronisation input low resets all output dividers for realignment.
// R14: synchronisation input pulled up, so a floating pin never resets dividers.
// R15: interrupt and lock outputs are open-drain, pulling low only.
// R16: every asynchronous control input passes a two-stage synchroniser first.
package fp_pkg;

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam int FP_STATUS_W = 8;
    localparam logic FP_PULL_SEL = 1'b1;
    localparam logic FP_PULL_CS_N = 1'b1;
    localparam logic FP_PULL_LP_N = 1'b1;
    localparam logic FP_PULL_RST_N = 1'b1;
    localparam logic FP_PULL_OE_N = 1'b0;
    localparam logic FP_PULL_SYNC_N = 1'b1;
    localparam logic FP_SEL_I2C = 1'b1;
    localparam logic FP_RST_IRQ = 1'b0;
    localparam logic FP_RST_CLK_EN = 1'b0;
    localparam logic [FP_STATUS_W-1:0] FP_RST_STATUS = 8'h00;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    // pin levels as seen at the package pads
    typedef struct packed {
        logic sel;
        logic sda;
        logic a1;
        logic sclk;
        logic a0_cs_n;
        logic reset_n;
        logic low_power_n;
        logic oe_n;
        logic realign_n;
    } fp_pins_t;

    // serial side handed to the register engine
    typedef struct packed {
        logic i2c;
        logic sclk;
        logic sdi;
        logic select_n;
        logic addr1;
        logic addr0;
    } fp_ser_t;

    // what the register engine wants on the data pins
    typedef struct packed {
        logic four_wire;
        logic dout;
        logic dout_en;
    } fp_eng_t;

endpackage

//--- src/fp_front.sv
`timescale 1ns/1ps
module fp_front
    import fp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire fp_pins_t pin_in,
    input wire fp_pins_t pin_float,
    input wire fp_eng_t eng,
    input wire logic [FP_STATUS_W-1:0] status,
    input wire logic irq_clear,
    input wire logic pll_locked,
    output fp_ser_t ser_q,
    output logic sda_out_q,
    output logic sda_oe_q,
    output logic addr_bit1_or_serial_out_q,
    output logic addr_bit1_or_serial_out_oe_q,
    output logic irq_n_out_q,
    output logic irq_n_oe_q,
    output logic lock_lost_n_out_q,
    output logic lock_lost_n_oe_q,
    output logic low_power_q,
    output logic clk_out_en_q,
    output logic div_reset_q,
    output logic logic_reset_q
);

    // ----------------------------------------------------------------
    // pull resolution
    // ----------------------------------------------------------------
    function automatic logic pull(input logic lvl, input logic flt,
                                  input logic pv);
        pull = flt ? pv : lvl;
    endfunction

    fp_pins_t pin_res;

    always_comb begin
        pin_res = pin_in;
        pin_res.sel = pull(pin_in.sel, pin_float.sel, FP_PULL_SEL); // R2
        pin_res.a0_cs_n = pull(pin_in.a0_cs_n, pin_float.a0_cs_n,
                               FP_PULL_CS_N); // R6
        pin_res.low_power_n = pull(pin_in.low_power_n,
                                   pin_float.low_power_n,
                                   FP_PULL_LP_N); // R8
        pin_res.reset_n = pull(pin_in.reset_n, pin_float.reset_n,
                               FP_PULL_RST_N);
        pin_res.oe_n = pull(pin_in.oe_n, pin_float.oe_n,
                            FP_PULL_OE_N); // R11
        pin_res.realign_n = pull(pin_in.realign_n, pin_float.realign_n,
                                 FP_PULL_SYNC_N); // R14
    end

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    fp_pins_t meta_q;
    fp_pins_t sync_q;

    // first stage read only by second
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= '1;
            sync_q <= '1;
        end else if (ce) begin
            meta_q <= pin_res; // R16
            sync_q <= meta_q; // R16
        end
    end

    // ----------------------------------------------------------------
    // device reset
    // ----------------------------------------------------------------
    logic int_rst;

    assign int_rst = rst | ~sync_q.reset_n; // R9

    always_ff @(posedge mclk) begin
        if (rst) begin
            logic_reset_q <= 1'b1;
        end else if (ce) begin
            logic_reset_q <= ~sync_q.reset_n; // R9
        end
    end

    // ----------------------------------------------------------------
    // serial port mux
    // ----------------------------------------------------------------
    logic mode_i2c;
    logic spi4;

    assign mode_i2c = (sync_q.sel == FP_SEL_I2C); // R1
    assign spi4 = ~mode_i2c & eng.four_wire;

    always_ff @(posedge mclk) begin
        if (int_rst) begin
            ser_q <= '{i2c: 1'b1, sclk: 1'b1, sdi: 1'b1, select_n: 1'b1,
                       addr1: 1'b0, addr0: 1'b0};
        end else if (ce) begin
            ser_q.i2c <= mode_i2c; // R1
            ser_q.sclk <= sync_q.sclk; // R5
            ser_q.sdi <= sync_q.sda; // R3
            ser_q.select_n <= mode_i2c | sync_q.a0_cs_n; // R6
            ser_q.addr1 <= mode_i2c & sync_q.a1; // R4
            ser_q.addr0 <= mode_i2c & sync_q.a0_cs_n; // R6
        end
    end

    always_ff @(posedge mclk) begin
        if (int_rst) begin
            sda_out_q <= 1'b0;
            sda_oe_q <= 1'b0;
            addr_bit1_or_serial_out_q <= 1'b0;
            addr_bit1_or_serial_out_oe_q <= 1'b0;
        end else if (ce) begin
            sda_out_q <= eng.dout;
            sda_oe_q <= eng.dout_en & ~spi4; // R3
            addr_bit1_or_serial_out_q <= eng.dout;
            addr_bit1_or_serial_out_oe_q <= eng.dout_en & spi4; // R4
        end
    end

    // ----------------------------------------------------------------
    // status and interrupt
    // ----------------------------------------------------------------
    logic [FP_STATUS_W-1:0] status_q;
    logic irq_pend_q;
    logic change;

    assign change = (status != status_q);

    always_ff @(posedge mclk) begin
        if (int_rst) begin
            status_q <= FP_RST_STATUS;
        end else if (ce) begin
            status_q <= status;
        end
    end

    // set beats clear
    always_ff @(posedge mclk) begin
        if (int_rst) begin
            irq_pend_q <= FP_RST_IRQ;
        end else if (ce) begin
            irq_pend_q <= change | (irq_pend_q & ~irq_clear); // R7
        end
    end

    always_ff @(posedge mclk) begin
        if (int_rst) begin
            irq_n_out_q <= 1'b0;
            irq_n_oe_q <= 1'b0;
            lock_lost_n_out_q <= 1'b0;
            lock_lost_n_oe_q <= 1'b1;
        end else if (ce) begin
            irq_n_out_q <= 1'b0; // R15
            irq_n_oe_q <= change | (irq_pend_q & ~irq_clear); // R7
            lock_lost_n_out_q <= 1'b0; // R15
            lock_lost_n_oe_q <= ~pll_locked; // R12
        end
    end

    // ----------------------------------------------------------------
    // power, output enable, divider realign
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (int_rst) begin
            clk_out_en_q <= FP_RST_CLK_EN; // R10
        end else if (ce) begin
            clk_out_en_q <= ~sync_q.oe_n; // R11
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            low_power_q <= 1'b0;
            div_reset_q <= 1'b0;
        end else if (ce) begin
            low_power_q <= ~sync_q.low_power_n; // R8
            div_reset_q <= ~sync_q.realign_n; // R13
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_sel_i2c_mode: assert property ( // R1
        ce && !int_rst && sync_q.sel |=> ser_q.i2c)
        else $error("select high did not give i2c");
    a_float_sel_pull: assert property ( // R2
        (pin_float.sel && ce && !int_rst)[*3] |=> ser_q.i2c)
        else $error("floating select not i2c");
    a_spi4_sda_in: assert property ( // R3
        ce && !int_rst && spi4 |=> !sda_oe_q)
        else $error("sda driven in 4-wire spi");
    a_sdo_i2c_off: assert property ( // R4
        ce && !int_rst && mode_i2c |=> !addr_bit1_or_serial_out_oe_q)
        else $error("a1 pin driven in i2c");
    a_sclk_follow: assert property ( // R5
        ce && !int_rst |=> ser_q.sclk == $past(sync_q.sclk))
        else $error("serial clock not forwarded");
    a_cs_in_i2c: assert property ( // R6
        ce && !int_rst && mode_i2c |=> ser_q.select_n)
        else $error("select active in i2c");
    a_irq_on_change: assert property ( // R7
        ce && !int_rst && change |=> irq_n_oe_q && !irq_n_out_q)
        else $error("status change did not pull irq low");
    a_irq_hold: assert property ( // R7
        ce && !int_rst && irq_pend_q && !irq_clear |=> irq_n_oe_q)
        else $error("irq released without clear");
    a_low_power: assert property ( // R8
        ce && !sync_q.low_power_n |=> low_power_q)
        else $error("low power not entered");
    a_reset_outs: assert property ( // R10
        ce && !sync_q.reset_n |=> !clk_out_en_q && !irq_n_oe_q)
        else $error("outputs active in device reset");
    a_oe_disable: assert property ( // R11
        ce && sync_q.oe_n |=> !clk_out_en_q)
        else $error("outputs on with enable high");
    a_lock_pin: assert property ( // R12
        ce && !int_rst |=> lock_lost_n_oe_q == !$past(pll_locked))
        else $error("lock pin wrong");
    a_div_realign: assert property ( // R13
        !rst && ce && !pin_res.realign_n ##1 ce ##1 ce |=> div_reset_q)
        else $error("divider reset missing");
    a_open_drain: assert property ( // R15
        !irq_n_out_q && !lock_lost_n_out_q)
        else $error("open-drain pin driven high");
    a_sync_stages: assert property ( // R16
        !rst && ce ##1 ce |=> sync_q == $past(pin_res, 2))
        else $error("synchroniser delay wrong");

    c_i2c_mode: cover property (ser_q.i2c && !logic_reset_q);
    c_spi4_out: cover property (addr_bit1_or_serial_out_oe_q);
    c_irq_event: cover property (irq_n_oe_q ##1 irq_clear);
    c_div_reset: cover property (div_reset_q);

endmodule

//--- bench/fp_host.sv
`timescale 1ns/1ps
module fp_host
    import fp_pkg::*;
(
    input wire logic mclk,
    input wire logic spi,
    input wire logic go,
    input wire logic dev_oe,
    input wire logic dev_o,
    output logic sclk,
    output logic cs_n,
    output logic sda_w,
    output logic busy
);
    logic [7:0] sh_q = 8'ha5;
    logic en_q = 1'b0;
    logic last_q = 1'b1;
    logic sclk_q = 1'b1;
    logic cs_n_q = 1'b1;
    logic busy_q = 1'b0;
    int n_q = 0;
    assign sclk = sclk_q;
    assign cs_n = cs_n_q;
    assign busy = busy_q;
    // released line: pull-up in i2c, changing pattern in spi
    assign sda_w = dev_oe ? dev_o : en_q ? sh_q[7] : spi ? !last_q : 1'b1;
    always @(posedge mclk) begin
        last_q <= sda_w;
        if (go && !busy_q) begin
            busy_q <= 1'b1;
            cs_n_q <= !spi;
            en_q <= 1'b1;
            n_q <= 0;
        end else if (busy_q) begin
            n_q <= n_q + 1;
            if (n_q[1:0] == 2'h3) sclk_q <= !sclk_q;
            // launch on falling sclk; first bit is out before the first fall
            if (n_q[2:0] == 3'h3 && n_q != 3) sh_q <= {sh_q[6:0], sh_q[7]};
            // select held one cycle past the last rising sclk
            if (n_q == 64) begin
                busy_q <= 1'b0;
                en_q <= 1'b0;
                cs_n_q <= 1'b1;
            end
        end
    end
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
    import fp_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    fp_pins_t p = 9'h1fd;
    fp_pins_t f = 9'h000;
    fp_pins_t pin_in;
    fp_eng_t eng = 3'h0;
    logic [FP_STATUS_W-1:0] status = 8'h00;
    logic irq_clear = 1'b0;
    logic pll_locked = 1'b1;
    logic go = 1'b0;
    logic h_sclk, h_cs_n, sda_w, busy;
    fp_ser_t ser_q;
    logic sda_o, sda_oe, so_o, so_oe, irq_o, irq_oe, lol_o, lol_oe;
    logic low_power_q, clk_out_en_q, div_reset_q, logic_reset_q;
    logic [2:0] hq[$];
    int mismatches = 0;
    int total_checks = 0;
    assign pin_in = {p.sel, sda_w, so_oe ? so_o : p.a1, h_sclk,
                     p.sel ? p.a0_cs_n : h_cs_n, p[3:0]};
    fp_host fp_host_i (.mclk(mclk), .spi(!p.sel), .go(go), .dev_oe(sda_oe),
        .dev_o(sda_o), .sclk(h_sclk), .cs_n(h_cs_n), .sda_w(sda_w),
        .busy(busy));
    fp_front fp_front_i (.mclk(mclk), .rst(rst), .ce(ce), .pin_in(pin_in),
        .pin_float(f), .eng(eng), .status(status), .irq_clear(irq_clear),
        .pll_locked(pll_locked), .ser_q(ser_q), .sda_out_q(sda_o),
        .sda_oe_q(sda_oe), .addr_bit1_or_serial_out_q(so_o),
        .addr_bit1_or_serial_out_oe_q(so_oe), .irq_n_out_q(irq_o),
        .irq_n_oe_q(irq_oe), .lock_lost_n_out_q(lol_o),
        .lock_lost_n_oe_q(lol_oe), .low_power_q(low_power_q),
        .clk_out_en_q(clk_out_en_q), .div_reset_q(div_reset_q),
        .logic_reset_q(logic_reset_q));
    initial begin
        forever #10 mclk = ~mclk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (e !== g) begin
            mismatches++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #60000;
        mismatches++;
        tally_and_finish;
    end
    initial begin
        step(15);
        chk(8'h00, clk_out_en_q);
        @(posedge mclk);
        rst <= 1'b0;
        step(4);
        chk(8'h00, logic_reset_q);
        chk(8'h01, clk_out_en_q);
        @(posedge mclk);
        p.oe_n <= 1'b1;
        step(2);
        chk(8'h01, clk_out_en_q);
        step(1);
        chk(8'h00, clk_out_en_q);
        @(posedge mclk);
        f.oe_n <= 1'b1;
        p.low_power_n <= 1'b0;
        p.realign_n <= 1'b0;
        step(3);
        chk(8'h01, clk_out_en_q);
        chk(8'h01, low_power_q);
        chk(8'h01, div_reset_q);
        @(posedge mclk);
        f <= 9'h007;
        step(3);
        chk(8'h00, low_power_q);
        chk(8'h00, div_reset_q);
        @(posedge mclk);
        p.a1 <= 1'b0;
        p.a0_cs_n <= 1'b1;
        step(3);
        chk(8'h3d, ser_q);
        @(posedge mclk);
        p.sel <= 1'b0;
        f <= 9'h000;
        step(3);
        chk(8'h00, ser_q.i2c);
        chk(8'h00, ser_q.addr0);
        @(posedge mclk);
        f.sel <= 1'b1;
        step(3);
        chk(8'h01, ser_q.i2c);
        @(posedge mclk);
        f.sel <= 1'b0;
        eng <= 3'h7;
        step(3);
        chk(8'h03, {so_oe, so_o});
        chk(8'h00, sda_oe);
        @(posedge mclk);
        eng <= 3'h1;
        step(1);
        chk(8'h02, {sda_oe, sda_o});
        chk(8'h00, so_oe);
        @(posedge mclk);
        eng <= 3'h4;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (72) begin
            step(1);
            hq.push_back({pin_in.sclk, pin_in.sda, pin_in.a0_cs_n});
            if (hq.size() > 3)
                chk(hq.pop_front(), {ser_q.sclk, ser_q.sdi, ser_q.select_n});
        end
        @(posedge mclk);
        status <= 8'h10;
        step(1);
        chk(8'h01, irq_oe);
        chk(8'h00, irq_o);
        @(posedge mclk);
        irq_clear <= 1'b1;
        status <= 8'h30;
        step(1);
        chk(8'h01, irq_oe);
        step(1);
        chk(8'h00, irq_oe);
        @(posedge mclk);
        irq_clear <= 1'b0;
        pll_locked <= 1'b0;
        status <= 8'h31;
        step(1);
        chk(8'h02, {lol_oe, lol_o});
        @(posedge mclk);
        pll_locked <= 1'b1;
        ce <= 1'b0;
        p.oe_n <= 1'b0;
        step(4);
        chk(8'h02, {lol_oe, clk_out_en_q});
        @(posedge mclk);
        ce <= 1'b1;
        p.reset_n <= 1'b0;
        step(3);
        chk(8'h01, logic_reset_q);
        chk(8'h00, {clk_out_en_q, irq_oe});
        @(posedge mclk);
        p.reset_n <= 1'b1;
        step(4);
        chk(8'h00, lol_oe);
        tally_and_finish;
    end
endmodule
